// ===== logic/mrs_pkg.sv
// Package of operation codes, flag positions and reset values for the rotate/subtract/skip datapath
package mrs_pkg;

    // Operations carried out by this datapath
    typedef enum logic [4:0] {
        MRS_OP_NONE,
        MRS_OP_ROTATE_LEFT_THRU_CARRY_MEM,
        MRS_OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING,
        MRS_OP_ROTATE_RIGHT_MEM,
        MRS_OP_ROTATE_RIGHT_TO_WORKING,
        MRS_OP_ROTATE_RIGHT_VIA_CY_MEM,
        MRS_OP_ROTATE_RIGHT_VIA_CY_TO_WORKING,
        MRS_OP_MINUS_WITH_BORROW_TO_WORKING,
        MRS_OP_MINUS_WITH_BORROW_TO_MEM,
        MRS_OP_MINUS_TO_WORKING,
        MRS_OP_MINUS_IMM_TO_WORKING,
        MRS_OP_MINUS_TO_MEM,
        MRS_OP_DECREMENT_SKIP_ZERO_MEM,
        MRS_OP_DECREMENT_SKIP_ZERO_WORKING,
        MRS_OP_INCREMENT_SKIP_ZERO_MEM,
        MRS_OP_INCREMENT_SKIP_ZERO_WORKING,
        MRS_OP_BIT_HIGH_SKIP,
        MRS_OP_BYTE_SET,
        MRS_OP_BIT_SET,
        MRS_OP_NIBBLE_EXCHANGE_MEM,
        MRS_OP_NIBBLE_EXCHANGE_TO_WORKING
    } mrs_op_t;

    // Positions of the four arithmetic flags in the flag vector
    localparam int MRS_FLAG_CARRY_POS     = 0;
    localparam int MRS_FLAG_HALF_CARRY_POS = 1;
    localparam int MRS_FLAG_ZERO_POS      = 2;
    localparam int MRS_FLAG_SIGN_ERR_POS  = 3;
    localparam int MRS_FLAG_WIDTH         = 4;

    // Reset values, and the all-ones byte written by byte set
    localparam logic [7:0] MRS_WORKING_RESET = 8'h00;
    localparam logic [3:0] MRS_FLAGS_RESET   = 4'h0;
    localparam logic [7:0] MRS_WR_DATA_RESET = 8'h00;
    localparam logic [7:0] MRS_BYTE_ALL_ONES = 8'hff;

    // Cycles spent by an instruction
    localparam logic [1:0] MRS_CYCLES_NORMAL = 2'h1;
    localparam logic [1:0] MRS_CYCLES_SKIP   = 2'h2;

endpackage

// ===== logic/mrs_subtractor.sv
// Eight-bit adder used for all subtract forms, giving result and the four flags
`timescale 1ns/1ps
`default_nettype none
module mrs_subtractor
    import mrs_pkg::*;
(
    input  wire logic [7:0] working_in,
    input  wire logic [7:0] operand_in,
    input  wire logic       carry_in,
    output logic      [7:0] result_out,
    output logic      [3:0] flags_out
);

    logic [4:0] low_sum;
    logic [3:0] high_sum;
    logic [7:0] inv_operand;
    logic       carry_into_7;

    // Working plus inverted operand plus carry; nibble split exposes carry out of bit 3
    always_comb begin
        inv_operand  = ~operand_in;
        low_sum      = {1'b0, working_in[3:0]} + {1'b0, inv_operand[3:0]} + {4'h0, carry_in};
        high_sum     = {1'b0, working_in[6:4]} + {1'b0, inv_operand[6:4]} + {3'h0, low_sum[4]};
        carry_into_7 = high_sum[3];
        result_out   = {working_in[7] ^ inv_operand[7] ^ carry_into_7, high_sum[2:0], low_sum[3:0]};
        flags_out    = '0;
        flags_out[MRS_FLAG_ZERO_POS]       = (result_out == 8'h00);
        flags_out[MRS_FLAG_HALF_CARRY_POS] = low_sum[4];
        // Carry out of bit 7 means no borrow
        flags_out[MRS_FLAG_CARRY_POS] = (working_in[7] & inv_operand[7])
            | (carry_into_7 & (working_in[7] ^ inv_operand[7]));
        // Signed overflow: carry into bit 7 differs from carry out of it
        flags_out[MRS_FLAG_SIGN_ERR_POS] = carry_into_7 ^ flags_out[MRS_FLAG_CARRY_POS];
    end

endmodule
`default_nettype wire

// ===== logic/mrs_datapath.sv
// Execution datapath for rotate, subtract, skip, set and swap operations
`timescale 1ns/1ps
`default_nettype none
module mrs_datapath
    import mrs_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       exec_valid_in,
    input  wire mrs_op_t    op_in,
    input  wire logic [7:0] mem_data_in,
    input  wire logic [7:0] immediate_in,
    input  wire logic [2:0] bit_select_in,
    output logic [7:0]      working_register_out,
    output logic            carry_flag_out,
    output logic            half_carry_flag_out,
    output logic            zero_flag_out,
    output logic            sign_error_flag_out,
    output logic [7:0]      mem_wr_data_out,
    output logic            mem_wr_en_out,
    output logic            discard_fetch_out,
    output logic            busy_out
);

    // Operands are read combinationally in the cycle an op is taken, so the
    // sequencer must hold mem_data_in, immediate_in and bit_select_in up to
    // the taking edge and keep the byte address for the write-back pulse.
    // A skip costs one dummy cycle in which any offered op is dropped; this
    // stands in for the refetch after the prefetched word is thrown away.

    // Result and flag state
    logic [7:0] working_reg;
    logic [7:0] working_next;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;

    // Write-back port; data holds its last value between pulses
    logic [7:0] mem_wr_data_reg;
    logic [7:0] mem_wr_data_next;
    logic       mem_wr_en_reg;
    logic       mem_wr_en_next;

    // Skip sequencing
    logic       discard_reg;
    logic       discard_next;
    logic       busy_reg;
    logic       busy_next;

    // Subtractor wiring; one adder serves every subtract form
    // Only operand and carry-in differ between the forms
    logic [7:0] sub_operand;
    logic       sub_carry;
    logic [7:0] sub_result;
    logic [3:0] sub_flags;

    // Helper values
    logic       carry_now;
    logic [7:0] dec_value;
    logic [7:0] inc_value;
    logic [7:0] swapped;
    logic [7:0] bit_mask;
    logic       bit_hit;
    logic       take;

    // Dummy cycle state of a skip
    // Two states suffice: no op is taken in the dummy cycle itself
    typedef enum logic {
        MRS_ST_RUN,
        MRS_ST_DUMMY
    } mrs_state_t;

    mrs_state_t state_reg;
    mrs_state_t state_next;

    // Stored carry feeds the rotates through carry and the borrow forms
    assign carry_now = flags_reg[MRS_FLAG_CARRY_POS];

    // Operand for the shared subtractor: immediate or memory, carry-in or forced one
    always_comb begin
        sub_operand = mem_data_in;
        sub_carry   = 1'b1;
        // Only the immediate form bypasses the memory byte
        if (op_in == MRS_OP_MINUS_IMM_TO_WORKING) begin
            sub_operand = immediate_in;
        end
        // Borrow forms take the stored carry, where one means no borrow
        if (op_in == MRS_OP_MINUS_WITH_BORROW_TO_WORKING ||
            op_in == MRS_OP_MINUS_WITH_BORROW_TO_MEM) begin
            sub_carry = carry_now;
        end
    end

    mrs_subtractor u_subtractor (
        .working_in (working_reg),
        .operand_in (sub_operand),
        .carry_in   (sub_carry),
        .result_out (sub_result),
        .flags_out  (sub_flags)
    );

    // Shared small operators; the counters wrap, so 01 for the decrement and ff for the increment give the skip cases
    always_comb begin
        dec_value = mem_data_in - 8'h01;
        inc_value = mem_data_in + 8'h01;
        swapped   = {mem_data_in[3:0], mem_data_in[7:4]};
    end

    // One select decoder per bit, shared by bit set and the bit-high skip
    for (genvar gi = 0; gi < 8; gi++) begin : g_bit_sel
        assign bit_mask[gi] = (bit_select_in == 3'(gi));
    end

    // Selected bit of the memory byte, for the skip test
    assign bit_hit = |(mem_data_in & bit_mask);

    // An instruction is only accepted outside the dummy cycle of a skip
    // Ops offered in the dummy cycle are dropped, not held over
    assign take = exec_valid_in && (state_reg == MRS_ST_RUN);

    // Next values of result, flags, write port and skip hit
    // Defaults: results and flags hold, pulses drop
    always_comb begin
        working_next     = working_reg;
        flags_next       = flags_reg;
        mem_wr_data_next = mem_wr_data_reg;
        mem_wr_en_next   = 1'b0;
        discard_next     = 1'b0;
        if (take) begin
            unique case (op_in)
                // Idle slot: state holds, no pulses
                MRS_OP_NONE: begin
                end
                // Old carry enters bit 0, bit 7 leaves into carry
                MRS_OP_ROTATE_LEFT_THRU_CARRY_MEM: begin
                    mem_wr_data_next = {mem_data_in[6:0], carry_now};
                    mem_wr_en_next   = 1'b1;
                    flags_next[MRS_FLAG_CARRY_POS] = mem_data_in[7];
                end
                // Same rotate into the working register; memory untouched
                MRS_OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING: begin
                    working_next = {mem_data_in[6:0], carry_now};
                    flags_next[MRS_FLAG_CARRY_POS] = mem_data_in[7];
                end
                // Plain rotate: bit 0 wraps to bit 7, flags hold
                MRS_OP_ROTATE_RIGHT_MEM: begin
                    mem_wr_data_next = {mem_data_in[0], mem_data_in[7:1]};
                    mem_wr_en_next   = 1'b1;
                end
                // Plain rotate into the working register
                MRS_OP_ROTATE_RIGHT_TO_WORKING: begin
                    working_next = {mem_data_in[0], mem_data_in[7:1]};
                end
                // Old carry enters bit 7, bit 0 leaves into carry
                MRS_OP_ROTATE_RIGHT_VIA_CY_MEM: begin
                    mem_wr_data_next = {carry_now, mem_data_in[7:1]};
                    mem_wr_en_next   = 1'b1;
                    flags_next[MRS_FLAG_CARRY_POS] = mem_data_in[0];
                end
                // Same right rotate into the working register
                MRS_OP_ROTATE_RIGHT_VIA_CY_TO_WORKING: begin
                    working_next = {carry_now, mem_data_in[7:1]};
                    flags_next[MRS_FLAG_CARRY_POS] = mem_data_in[0];
                end
                // Subtract forms writing the working register; all four flags follow
                MRS_OP_MINUS_WITH_BORROW_TO_WORKING,
                MRS_OP_MINUS_TO_WORKING,
                MRS_OP_MINUS_IMM_TO_WORKING: begin
                    working_next = sub_result;
                    flags_next   = sub_flags;
                end
                // Subtract forms writing memory; the working register holds
                MRS_OP_MINUS_WITH_BORROW_TO_MEM,
                MRS_OP_MINUS_TO_MEM: begin
                    mem_wr_data_next = sub_result;
                    mem_wr_en_next   = 1'b1;
                    flags_next       = sub_flags;
                end
                // A zero result buys the skip; flags hold
                MRS_OP_DECREMENT_SKIP_ZERO_MEM: begin
                    mem_wr_data_next = dec_value;
                    mem_wr_en_next   = 1'b1;
                    discard_next     = (dec_value == 8'h00);
                end
                // Decrement into the working register, memory untouched
                MRS_OP_DECREMENT_SKIP_ZERO_WORKING: begin
                    working_next = dec_value;
                    discard_next = (dec_value == 8'h00);
                end
                // Increment wraps ff to 00, which is the skip case
                MRS_OP_INCREMENT_SKIP_ZERO_MEM: begin
                    mem_wr_data_next = inc_value;
                    mem_wr_en_next   = 1'b1;
                    discard_next     = (inc_value == 8'h00);
                end
                // Increment into the working register, memory untouched
                MRS_OP_INCREMENT_SKIP_ZERO_WORKING: begin
                    working_next = inc_value;
                    discard_next = (inc_value == 8'h00);
                end
                // Test only: no write-back and no flag change
                MRS_OP_BIT_HIGH_SKIP: begin
                    discard_next = bit_hit;
                end
                // Every bit forced high
                MRS_OP_BYTE_SET: begin
                    mem_wr_data_next = MRS_BYTE_ALL_ONES;
                    mem_wr_en_next   = 1'b1;
                end
                // Other seven bits pass through unchanged
                MRS_OP_BIT_SET: begin
                    mem_wr_data_next = mem_data_in | bit_mask;
                    mem_wr_en_next   = 1'b1;
                end
                // Halves exchanged in place
                MRS_OP_NIBBLE_EXCHANGE_MEM: begin
                    mem_wr_data_next = swapped;
                    mem_wr_en_next   = 1'b1;
                end
                MRS_OP_NIBBLE_EXCHANGE_TO_WORKING: begin
                    working_next = swapped;
                    // Write port stays idle and flags hold
                    mem_wr_en_next = 1'b0;
                end
                // Codes past the last operation are dropped as idle slots
                default: begin
                end
            endcase
        end
    end

    // Result, flag, write-back and discard-pulse registers only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            working_reg     <= MRS_WORKING_RESET;
            flags_reg       <= MRS_FLAGS_RESET;
            mem_wr_data_reg <= MRS_WR_DATA_RESET;
            mem_wr_en_reg   <= 1'b0;
            discard_reg     <= 1'b0;
        end else begin
            working_reg     <= working_next;
            flags_reg       <= flags_next;
            mem_wr_data_reg <= mem_wr_data_next;
            mem_wr_en_reg   <= mem_wr_en_next;
            discard_reg     <= discard_next;
        end
    end

    // Skip sequencing: a hit buys exactly one dummy cycle, and since no op is
    // taken in that cycle two dummies can never follow each other
    always_comb begin
        state_next = MRS_ST_RUN;
        busy_next  = 1'b0;
        if (take && discard_next) begin
            state_next = MRS_ST_DUMMY;
            busy_next  = 1'b1;
        end
    end

    // Skip sequencing registers only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_reg  <= 1'b0;
            state_reg <= MRS_ST_RUN;
        end else begin
            busy_reg  <= busy_next;
            state_reg <= state_next;
        end
    end

    // Outputs straight from the registers: working register and flags
    assign working_register_out = working_reg;
    assign carry_flag_out       = flags_reg[MRS_FLAG_CARRY_POS];
    assign half_carry_flag_out  = flags_reg[MRS_FLAG_HALF_CARRY_POS];
    assign zero_flag_out        = flags_reg[MRS_FLAG_ZERO_POS];
    assign sign_error_flag_out  = flags_reg[MRS_FLAG_SIGN_ERR_POS];

    // Write-back and skip pulses, one cycle each
    assign mem_wr_data_out      = mem_wr_data_reg;
    assign mem_wr_en_out        = mem_wr_en_reg;
    assign discard_fetch_out    = discard_reg;
    assign busy_out             = busy_reg;

endmodule
`default_nettype wire

// ===== tb/mrs_datapath_checker.sv
// Concurrent checks on the ports of the rotate/subtract/skip datapath
`timescale 1ns/1ps
`default_nettype none
module mrs_datapath_checker
    import mrs_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       exec_valid_in,
    input wire mrs_op_t    op_in,
    input wire logic [7:0] mem_data_in,
    input wire logic [7:0] immediate_in,
    input wire logic [2:0] bit_select_in,
    input wire logic [7:0] working_register_out,
    input wire logic       carry_flag_out,
    input wire logic       half_carry_flag_out,
    input wire logic       zero_flag_out,
    input wire logic       sign_error_flag_out,
    input wire logic [7:0] mem_wr_data_out,
    input wire logic       mem_wr_en_out,
    input wire logic       discard_fetch_out,
    input wire logic       busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] flags;
    logic       take;
    // Ops presented in the dummy cycle are not taken, so every check but a_dummy_drops_op keys on this
    assign flags = {sign_error_flag_out, zero_flag_out, half_carry_flag_out, carry_flag_out};
    assign take  = exec_valid_in && !busy_out;

    a_rotl_mem_carry: assert property (take && op_in == MRS_OP_ROTATE_LEFT_THRU_CARRY_MEM |=>
        mem_wr_en_out && carry_flag_out == $past(mem_data_in[7])
        && mem_wr_data_out == {$past(mem_data_in[6:0]), $past(carry_flag_out)})
        else $error("rotate left via carry wrong");
    a_rotr_work_flags: assert property (take && op_in == MRS_OP_ROTATE_RIGHT_TO_WORKING |=>
        working_register_out == {$past(mem_data_in[0]), $past(mem_data_in[7:1])}
        && !mem_wr_en_out && flags == $past(flags))
        else $error("rotate right to working wrong");
    a_sub_result: assert property (take && op_in == MRS_OP_MINUS_TO_WORKING |=>
        {carry_flag_out, working_register_out} == {1'b0, $past(working_register_out)}
        + {1'b0, ~$past(mem_data_in)} + 9'h001 && zero_flag_out == (working_register_out == 8'h00))
        else $error("subtract result or flags wrong");
    a_dec_skip_dummy: assert property (take && op_in == MRS_OP_DECREMENT_SKIP_ZERO_MEM
        && mem_data_in == 8'h01 |=> discard_fetch_out && busy_out && mem_wr_data_out == 8'h00
        ##1 !mem_wr_en_out && !discard_fetch_out && !busy_out)
        else $error("skip on zero decrement wrong");
    a_inc_no_skip: assert property (take && op_in == MRS_OP_INCREMENT_SKIP_ZERO_WORKING
        && mem_data_in != 8'hff |=> !discard_fetch_out && !mem_wr_en_out
        && working_register_out == $past(mem_data_in) + 8'h01)
        else $error("increment to working wrong");
    a_bit_high_skip: assert property (take && op_in == MRS_OP_BIT_HIGH_SKIP |=>
        discard_fetch_out == $past(mem_data_in[bit_select_in]) && !mem_wr_en_out
        && flags == $past(flags))
        else $error("bit skip wrong");
    a_bit_set_only: assert property (take && op_in == MRS_OP_BIT_SET |=> mem_wr_en_out
        && mem_wr_data_out == ($past(mem_data_in) | (8'h01 << $past(bit_select_in))))
        else $error("bit set wrong");
    a_swap_work_keep: assert property (take && op_in == MRS_OP_NIBBLE_EXCHANGE_TO_WORKING |=>
        working_register_out == {$past(mem_data_in[3:0]), $past(mem_data_in[7:4])}
        && !mem_wr_en_out && flags == $past(flags))
        else $error("swap to working wrong");
    a_byte_set_ones: assert property (take && op_in == MRS_OP_BYTE_SET |=>
        mem_wr_en_out && mem_wr_data_out == MRS_BYTE_ALL_ONES && flags == $past(flags))
        else $error("byte set wrong");
    a_dummy_drops_op: assert property (busy_out |=>
        !mem_wr_en_out && !busy_out && !discard_fetch_out && $stable(working_register_out))
        else $error("op taken in dummy cycle");
endmodule

bind mrs_datapath mrs_datapath_checker mrs_datapath_checker_inst (.*);
`default_nettype wire

// ===== tb/mcu_rotate_subtract_skip_ops_tb_top.sv
// Self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/1ps
`default_nettype none
module mcu_rotate_subtract_skip_ops_tb_top;
    import mrs_pkg::*;
    typedef struct packed {
        logic [7:0] w;
        logic [3:0] f;
        logic       we;
        logic [7:0] wd;
        logic       dis;
    } mrs_note_t;
    logic       core_clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       exec_valid_in = 1'b0;
    mrs_op_t    op_in = MRS_OP_NONE;
    logic [7:0] mem_data_in = 8'h00;
    logic [7:0] immediate_in = 8'h00;
    logic [2:0] bit_select_in = 3'h0;
    logic [7:0] working_register_out, mem_wr_data_out;
    logic       carry_flag_out, half_carry_flag_out, zero_flag_out, sign_error_flag_out;
    logic       mem_wr_en_out, discard_fetch_out, busy_out;
    logic [7:0] w_m = 8'h00;
    logic [3:0] f_m = 4'h0;
    logic       skip_m = 1'b0;
    mrs_note_t  q[$];
    mrs_note_t  n;
    int         miscompares = 0;
    int         n_checks = 0;
    int         cyc = 0;

    mrs_datapath mrs_datapath_inst (.*);

    initial forever #2.5 core_clk_in = ~core_clk_in;

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Drive one cycle just after the edge and note what the next edge must show
    task automatic issue(input int k);
        mrs_op_t    o;
        mrs_note_t  e;
        string      nm;
        logic [7:0] m, r, y;
        logic [8:0] s;
        logic [4:0] h;
        logic       v, sk, c, ci, dummy;
        @(posedge core_clk_in);
        #1;
        o = mrs_op_t'(k >= 0 ? k : int'($urandom % 21));
        m = ($urandom % 3 == 0) ? 8'(8'hff + $urandom % 3) : 8'($urandom);
        v = k >= 0 || ($urandom % 4 != 0);
        exec_valid_in = v;
        op_in = o;
        mem_data_in = m;
        immediate_in = 8'($urandom);
        bit_select_in = 3'($urandom);
        nm = o.name();
        e = '0;
        sk = 1'b0;
        dummy = skip_m;
        skip_m = 1'b0;
        if (v && !dummy) begin
            c = f_m[0];
            r = w_m;
            case (o)
                MRS_OP_ROTATE_LEFT_THRU_CARRY_MEM, MRS_OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING: begin
                    r = {m[6:0], c};
                    f_m[0] = m[7];
                end
                MRS_OP_ROTATE_RIGHT_MEM, MRS_OP_ROTATE_RIGHT_TO_WORKING: r = {m[0], m[7:1]};
                MRS_OP_ROTATE_RIGHT_VIA_CY_MEM, MRS_OP_ROTATE_RIGHT_VIA_CY_TO_WORKING: begin
                    r = {c, m[7:1]};
                    f_m[0] = m[0];
                end
                MRS_OP_DECREMENT_SKIP_ZERO_MEM, MRS_OP_DECREMENT_SKIP_ZERO_WORKING: begin
                    r = m - 8'h01;
                    sk = r == 8'h00;
                end
                MRS_OP_INCREMENT_SKIP_ZERO_MEM, MRS_OP_INCREMENT_SKIP_ZERO_WORKING: begin
                    r = m + 8'h01;
                    sk = r == 8'h00;
                end
                MRS_OP_BIT_HIGH_SKIP: sk = m[bit_select_in];
                MRS_OP_BYTE_SET: r = MRS_BYTE_ALL_ONES;
                MRS_OP_BIT_SET: r = m | (8'h01 << bit_select_in);
                MRS_OP_NIBBLE_EXCHANGE_MEM, MRS_OP_NIBBLE_EXCHANGE_TO_WORKING: r = {m[3:0], m[7:4]};
                MRS_OP_NONE: ;
                default: begin
                    // Every subtract form is an add of the inverted operand
                    y = (o == MRS_OP_MINUS_IMM_TO_WORKING) ? ~immediate_in : ~m;
                    ci = nm.substr(7, 12) == "MINUS_" && nm.substr(13, 16) == "WITH" ? c : 1'b1;
                    s = {1'b0, w_m} + {1'b0, y} + 9'(ci);
                    h = {1'b0, w_m[3:0]} + {1'b0, y[3:0]} + 5'(ci);
                    r = s[7:0];
                    f_m = {w_m[7] == y[7] && r[7] != w_m[7], r == 8'h00, h[4], s[8]};
                end
            endcase
            if (o inside {MRS_OP_BYTE_SET, MRS_OP_BIT_SET} || nm.substr(nm.len() - 3, nm.len() - 1) == "MEM") begin
                e.we = 1'b1;
                e.wd = r;
            end
            if (nm.substr(nm.len() - 4, nm.len() - 1) == "KING") w_m = r;
            skip_m = sk;
        end
        e.w = w_m;
        e.f = f_m;
        e.dis = sk;
        q.push_back(e);
    endtask

    // Watch the outputs one edge after each noted request
    initial begin
        forever begin
            @(posedge core_clk_in);
            if (q.size() > 0) begin
                @(negedge core_clk_in);
                n = q.pop_front();
                chk("working", n.w, working_register_out);
                chk("flags", {4'h0, n.f}, {4'h0, sign_error_flag_out, zero_flag_out,
                    half_carry_flag_out, carry_flag_out});
                chk_bit("write", n.we, mem_wr_en_out);
                if (n.we) chk("wdata", n.wd, mem_wr_data_out);
                chk_bit("skip", n.dis, discard_fetch_out);
                chk_bit("busy", n.dis, busy_out);
            end
        end
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(32'h8154));
        repeat (4) @(posedge core_clk_in);
        #1 rst_n_in = 1'b1;
        issue(0);
        for (int k = 0; k < 21; k++) issue(k);
        repeat (600) issue(-1);
        issue(0);
        repeat (3) @(posedge core_clk_in);
        end_sim();
    end
endmodule
`default_nettype wire
